// [verilog/sfprs_pkg.sv]
package sfprs_pkg;
  // clock and documented times
  localparam int CLK_MHZ             = 200;
  localparam int US_PER_MS           = 1000;
  localparam int SUPPLY_TO_SELECT_US = 30;
  localparam int WRITE_INHIBIT_MS    = 10;
  localparam int SELECT_CYCLES       = SUPPLY_TO_SELECT_US * CLK_MHZ;
  localparam int INHIBIT_CYCLES      =
    WRITE_INHIBIT_MS * US_PER_MS * CLK_MHZ;
  localparam int RECOVER_CYCLES      = 64;
  localparam int CNT_W               = 22;
  localparam int CYC_W               = 24;
  localparam int LOCK_W              = 16;

  // serial command codes
  localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_STATUS_WRITE  = 8'h01;
  localparam logic [7:0] OP_PAGE_REWRITE  = 8'h0A;
  localparam logic [7:0] OP_PAGE_PROGRAM  = 8'h02;
  localparam logic [7:0] OP_PAGE_ERASE    = 8'hDB;
  localparam logic [7:0] OP_LARGE_CLEAR   = 8'hD8;
  localparam logic [7:0] OP_SMALL_CLEAR   = 8'h20;
  localparam logic [7:0] OP_WHOLE_CLEAR   = 8'hC7;
  localparam logic [7:0] OP_DEEP_DOWN     = 8'hB9;
  localparam logic [7:0] OP_DEEP_RELEASE  = 8'hAB;
  localparam logic [2:0] OPCODE_LAST_BIT  = 3'h7;

  // register word indexes
  localparam logic [2:0] REG_STATUS = 3'h0;
  localparam logic [2:0] REG_LOCK   = 3'h1;
  localparam logic [2:0] REG_CYCLE  = 3'h2;
  localparam logic [2:0] REG_LASTOP = 3'h3;

  // status bit positions
  localparam int ST_WIP      = 0;
  localparam int ST_WEL      = 1;
  localparam int ST_DEEP     = 2;
  localparam int ST_SEL_OK   = 3;
  localparam int ST_WRITE_OK = 4;
  localparam int ST_RESET    = 5;
  localparam int ST_SUPPLY   = 6;
  localparam int ST_PENDING  = 7;

  localparam logic [CYC_W-1:0]  CYCLE_RESET = 24'h000400;
  localparam logic [LOCK_W-1:0] LOCK_RESET  = 16'h0000;

  typedef enum logic [1:0] {
    SFPRS_OFF,
    SFPRS_ON,
    SFPRS_RST,
    SFPRS_RECOVER
  } sfprs_power_type;
endpackage : sfprs_pkg

// [verilog/sfprs_sync.sv]
`timescale 1ns/100ps
`default_nettype none
module sfprs_sync #(
  parameter int               WIDTH       = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_sync_out;

  always_comb
  begin
    next_stage1   = async_in;
    next_sync_out = stage1;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      stage1   <= RESET_VALUE;
      sync_out <= RESET_VALUE;
    end
    else
    begin
      stage1   <= next_stage1;
      sync_out <= next_sync_out;
    end
  end
endmodule : sfprs_sync
`default_nettype wire

// [verilog/sfprs_top.sv]
// How it works
// - below threshold, logic held reset, commands ignored
// - write-class commands ignored during inhibit delay
// - reads accepted once select delay elapsed
// - powers up standby, latches and locks cleared
// - supply loss disables everything immediately
// - reset aborts running write, program, erase cycle
// - every reset pulse clears all lock bits
// - reset mid-decode abandons instruction, logic cleared
// - reset in self-timed cycle gives power-on state
// - reset in status write waits cycle end
// - reset while deselected restores power-on state
// - status bits start at zero
// - reset enters reset mode, then recovery wait
`timescale 1ns/100ps
`default_nettype none
module sfprs_top #(
  parameter int SELECT_CYCLES  = sfprs_pkg::SELECT_CYCLES,
  parameter int INHIBIT_CYCLES = sfprs_pkg::INHIBIT_CYCLES
) (
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        link_sclk,
  input  wire logic        device_select_n,
  input  wire logic        serial_data_in,
  input  wire logic        hw_clear_n,
  input  wire logic        supply_above_threshold,
  input  wire logic        supply_above_min,
  input  wire logic [2:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic             write_in_progress,
  output logic             reset_mode
);
  localparam int CNT_W = sfprs_pkg::CNT_W;
  localparam int CYC_W = sfprs_pkg::CYC_W;
  localparam int LCK_W = sfprs_pkg::LOCK_W;
  localparam logic [CNT_W-1:0] SEL_END = CNT_W'(SELECT_CYCLES);
  localparam logic [CNT_W-1:0] INH_END = CNT_W'(INHIBIT_CYCLES);
  localparam logic [CNT_W-1:0] REC_END =
    CNT_W'(sfprs_pkg::RECOVER_CYCLES);

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  be);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
        res[i*8 +: 8] = new_v[i*8 +: 8];
    end
    return res;
  endfunction : merge_bytes

  ////////////////////////////////////////////////////////////////////////
  // link domain: collect the opcode byte of each frame
  logic [2:0] bit_cnt;
  logic       byte_done;
  logic [6:0] shift;
  logic [7:0] opcode_link;
  logic       opcode_toggle;
  logic [2:0] next_bit_cnt;
  logic       next_byte_done;
  logic [6:0] next_shift;
  logic [7:0] next_opcode_link;
  logic       next_opcode_toggle;

  always_comb
  begin
    next_shift         = {shift[5:0], serial_data_in};
    next_bit_cnt       = bit_cnt + 3'h1;
    next_byte_done     = byte_done;
    next_opcode_link   = opcode_link;
    next_opcode_toggle = opcode_toggle;
    if (!byte_done && bit_cnt == sfprs_pkg::OPCODE_LAST_BIT)
    begin
      next_byte_done     = 1'b1;
      next_opcode_link   = {shift, serial_data_in};
      next_opcode_toggle = ~opcode_toggle;
    end
  end

  // frame counters end with the frame's own select
  always_ff @(posedge link_sclk or posedge device_select_n)
  begin
    if (device_select_n)
    begin
      bit_cnt   <= 3'h0;
      byte_done <= 1'b0;
      shift     <= 7'h00;
    end
    else
    begin
      bit_cnt   <= next_bit_cnt;
      byte_done <= next_byte_done;
      shift     <= next_shift;
    end
  end

  always_ff @(posedge link_sclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      opcode_link   <= 8'h00;
      opcode_toggle <= 1'b0;
    end
    else
    begin
      opcode_link   <= next_opcode_link;
      opcode_toggle <= next_opcode_toggle;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // crossings into the reference domain
  logic [4:0] sync_q;
  logic       thr_s;
  logic       min_s;
  logic       clr_n_s;
  logic       sel_n_s;
  logic       tog_s;

  // pins at rest: select and clear high, no false edge after reset
  localparam logic [4:0] SYNC_IDLE = 5'h06;

  sfprs_sync #(.WIDTH(5), .RESET_VALUE(SYNC_IDLE)) u_sync (
    .clk      (ref_clk),
    .rst      (sys_rst),
    .async_in ({supply_above_threshold, supply_above_min, hw_clear_n,
                device_select_n, opcode_toggle}),
    .sync_out (sync_q)
  );

  assign {thr_s, min_s, clr_n_s, sel_n_s, tog_s} = sync_q;

  ////////////////////////////////////////////////////////////////////////
  // power, reset and command state
  sfprs_pkg::sfprs_power_type power;
  sfprs_pkg::sfprs_power_type next_power;
  logic [CNT_W-1:0] sel_cnt, inh_cnt, rec_cnt;
  logic [CNT_W-1:0] next_sel_cnt, next_inh_cnt, next_rec_cnt;
  logic [CYC_W-1:0] cyc_cnt, cycle_len;
  logic [CYC_W-1:0] next_cyc_cnt, next_cycle_len;
  logic [LCK_W-1:0] lock_bits, next_lock_bits;
  logic [7:0]       frame_op, last_op, next_frame_op, next_last_op;
  logic             write_enable_latch, deep, busy, busy_status, pending;
  logic             next_wel, next_deep, next_busy, next_busy_status;
  logic             next_pending, next_wip, next_reset_mode;
  logic             frame_ok, frame_op_valid;
  logic             next_frame_ok, next_frame_op_valid;
  logic             sel_n_d, tog_d;
  logic             sel_ok, write_ok;
  logic             sel_fall, sel_rise, op_new, do_por, write_gate;
  logic [31:0]      status_word, rd_word, next_readdata;
  logic             next_waitrequest;

  always_comb
  begin
    sel_ok   = (power == sfprs_pkg::SFPRS_ON) && (sel_cnt == SEL_END);
    write_ok = inh_cnt == INH_END;
    sel_fall = sel_n_d && !sel_n_s;
    sel_rise = !sel_n_d && sel_n_s;
    op_new   = tog_d ^ tog_s;
    do_por   = 1'b0;
    write_gate          = write_enable_latch && !busy && !deep;
    next_power          = power;
    next_sel_cnt        = min_s ? sel_cnt : '0;
    next_inh_cnt        = inh_cnt;
    next_rec_cnt        = rec_cnt;
    next_cyc_cnt        = cyc_cnt;
    next_cycle_len      = cycle_len;
    next_lock_bits      = lock_bits;
    next_frame_op       = frame_op;
    next_last_op        = last_op;
    next_wel            = write_enable_latch;
    next_deep           = deep;
    next_busy           = busy;
    next_busy_status    = busy_status;
    next_pending        = pending;
    next_frame_ok       = frame_ok;
    next_frame_op_valid = frame_op_valid;
    if (min_s && sel_cnt != SEL_END)
      next_sel_cnt = sel_cnt + CNT_W'(1);
    if (inh_cnt != INH_END)
      next_inh_cnt = inh_cnt + CNT_W'(1);
    // software access to the control registers
    if (avs_write && !avs_waitrequest)
    begin
      if (avs_address == sfprs_pkg::REG_LOCK)
        next_lock_bits = LCK_W'(merge_bytes(32'(lock_bits), avs_writedata,
                                            avs_byteenable));
      if (avs_address == sfprs_pkg::REG_CYCLE)
        next_cycle_len = CYC_W'(merge_bytes(32'(cycle_len), avs_writedata,
                                            avs_byteenable));
    end
    // framing of serial commands
    if (sel_fall)
    begin
      next_frame_ok       = sel_ok;
      next_frame_op_valid = 1'b0;
    end
    if (op_new && frame_ok && !sel_n_s)
    begin
      next_frame_op       = opcode_link;
      next_last_op        = opcode_link;
      next_frame_op_valid = 1'b1;
    end
    if (sel_rise)
    begin
      next_frame_ok = 1'b0;
      if (frame_ok && frame_op_valid)
      begin
        if (deep)
        begin
          if (frame_op == sfprs_pkg::OP_DEEP_RELEASE)
            next_deep = 1'b0;
        end
        else
        begin
          unique case (frame_op)
            sfprs_pkg::OP_WRITE_ENABLE:
              if (write_ok && !busy)
                next_wel = 1'b1;
            sfprs_pkg::OP_WRITE_DISABLE:
              if (!busy)
                next_wel = 1'b0;
            sfprs_pkg::OP_DEEP_DOWN:
              if (!busy)
                next_deep = 1'b1;
            sfprs_pkg::OP_PAGE_REWRITE, sfprs_pkg::OP_PAGE_PROGRAM,
            sfprs_pkg::OP_PAGE_ERASE, sfprs_pkg::OP_LARGE_CLEAR:
              if (write_gate && write_ok)
              begin
                next_busy    = 1'b1;
                next_cyc_cnt = cycle_len;
              end
            sfprs_pkg::OP_SMALL_CLEAR, sfprs_pkg::OP_WHOLE_CLEAR,
            sfprs_pkg::OP_STATUS_WRITE:
              if (write_gate)
              begin
                next_busy        = 1'b1;
                next_busy_status =
                  frame_op == sfprs_pkg::OP_STATUS_WRITE;
                next_cyc_cnt     = cycle_len;
              end
            default:
            begin
            end
          endcase
        end
      end
    end
    // self-timed cycle
    if (busy)
    begin
      if (cyc_cnt == '0)
      begin
        next_busy        = 1'b0;
        next_busy_status = 1'b0;
        next_wel         = 1'b0;
        if (pending)
          do_por = 1'b1;
      end
      else
        next_cyc_cnt = cyc_cnt - CYC_W'(1);
    end
    // hardware reset pin
    if (!clr_n_s && power != sfprs_pkg::SFPRS_OFF)
    begin
      if (busy && busy_status)
        next_pending = 1'b1;
      else
        do_por = 1'b1;
    end
    unique case (power)
      sfprs_pkg::SFPRS_OFF:
        if (thr_s)
          next_power = clr_n_s ? sfprs_pkg::SFPRS_ON
                               : sfprs_pkg::SFPRS_RST;
      sfprs_pkg::SFPRS_RST:
        if (clr_n_s)
        begin
          next_power   = sfprs_pkg::SFPRS_RECOVER;
          next_rec_cnt = '0;
        end
      sfprs_pkg::SFPRS_RECOVER:
        if (rec_cnt == REC_END)
          next_power = sfprs_pkg::SFPRS_ON;
        else
          next_rec_cnt = rec_cnt + CNT_W'(1);
      sfprs_pkg::SFPRS_ON:
      begin
      end
    endcase
    if (do_por)
    begin
      next_power   = sfprs_pkg::SFPRS_RST;
      next_pending = 1'b0;
    end
    if (do_por || !thr_s)
    begin
      next_wel            = 1'b0;
      next_deep           = 1'b0;
      next_busy           = 1'b0;
      next_busy_status    = 1'b0;
      next_cyc_cnt        = '0;
      next_frame_ok       = 1'b0;
      next_frame_op_valid = 1'b0;
      next_lock_bits      = sfprs_pkg::LOCK_RESET;
    end
    if (!thr_s)
    begin
      next_power   = sfprs_pkg::SFPRS_OFF;
      next_pending = 1'b0;
      next_sel_cnt = '0;
      next_inh_cnt = '0;
    end
    next_wip        = next_busy;
    next_reset_mode = next_power != sfprs_pkg::SFPRS_ON;
  end

  ////////////////////////////////////////////////////////////////////////
  // register bus: one wait state, then the answer
  always_comb
  begin
    status_word = '0;
    status_word[sfprs_pkg::ST_WIP]      = busy;
    status_word[sfprs_pkg::ST_WEL]      = write_enable_latch;
    status_word[sfprs_pkg::ST_DEEP]     = deep;
    status_word[sfprs_pkg::ST_SEL_OK]   = sel_ok;
    status_word[sfprs_pkg::ST_WRITE_OK] = write_ok;
    status_word[sfprs_pkg::ST_RESET]    = power == sfprs_pkg::SFPRS_RST;
    status_word[sfprs_pkg::ST_SUPPLY]   = thr_s;
    status_word[sfprs_pkg::ST_PENDING]  = pending;
    unique case (avs_address)
      sfprs_pkg::REG_STATUS: rd_word = status_word;
      sfprs_pkg::REG_LOCK:   rd_word = 32'(lock_bits);
      sfprs_pkg::REG_CYCLE:  rd_word = 32'(cycle_len);
      sfprs_pkg::REG_LASTOP: rd_word = 32'(last_op);
      default:               rd_word = 32'h00000000;
    endcase
    next_waitrequest = !((avs_read || avs_write) && avs_waitrequest);
    next_readdata    = (avs_read && avs_waitrequest) ? rd_word : avs_readdata;
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      power             <= sfprs_pkg::SFPRS_OFF;
      sel_cnt           <= '0;
      inh_cnt           <= '0;
      rec_cnt           <= '0;
      cyc_cnt           <= '0;
      cycle_len         <= sfprs_pkg::CYCLE_RESET;
      lock_bits         <= sfprs_pkg::LOCK_RESET;
      frame_op          <= 8'h00;
      last_op           <= 8'h00;
      write_enable_latch               <= 1'b0;
      deep              <= 1'b0;
      busy              <= 1'b0;
      busy_status       <= 1'b0;
      pending           <= 1'b0;
      frame_ok          <= 1'b0;
      frame_op_valid    <= 1'b0;
      sel_n_d           <= 1'b1;
      tog_d             <= 1'b0;
      write_in_progress <= 1'b0;
      reset_mode        <= 1'b1;
      avs_waitrequest   <= 1'b1;
      avs_readdata      <= 32'h00000000;
    end
    else
    begin
      power             <= next_power;
      sel_cnt           <= next_sel_cnt;
      inh_cnt           <= next_inh_cnt;
      rec_cnt           <= next_rec_cnt;
      cyc_cnt           <= next_cyc_cnt;
      cycle_len         <= next_cycle_len;
      lock_bits         <= next_lock_bits;
      frame_op          <= next_frame_op;
      last_op           <= next_last_op;
      write_enable_latch               <= next_wel;
      deep              <= next_deep;
      busy              <= next_busy;
      busy_status       <= next_busy_status;
      pending           <= next_pending;
      frame_ok          <= next_frame_ok;
      frame_op_valid    <= next_frame_op_valid;
      sel_n_d           <= sel_n_s;
      tog_d             <= tog_s;
      write_in_progress <= next_wip;
      reset_mode        <= next_reset_mode;
      avs_waitrequest   <= next_waitrequest;
      avs_readdata      <= next_readdata;
    end
  end
endmodule : sfprs_top
`default_nettype wire

// [testbench/sfprs_top_sva.sv]
`timescale 1ns/100ps
`default_nettype none
module sfprs_top_sva (
  input wire logic        ref_clk,
  input wire logic        sys_rst,
  input wire logic        hw_clear_n,
  input wire logic        supply_above_threshold,
  input wire logic [2:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        write_in_progress,
  input wire logic        reset_mode
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  a_supply_mode: assert property (
    !supply_above_threshold |-> ##[1:4] reset_mode)
    else $error("supply low but not in reset mode");
  a_supply_wip: assert property (
    !supply_above_threshold [*6] |-> !write_in_progress)
    else $error("cycle kept running after supply loss");
  a_mode_wip: assert property (
    reset_mode [*2] |-> !write_in_progress)
    else $error("cycle running in reset mode");
  a_clear_mode: assert property (
    (!hw_clear_n && !write_in_progress) [*5] |-> reset_mode)
    else $error("clear held low without reset mode");
  a_recover_hold: assert property (
    reset_mode && $rose(hw_clear_n) |-> reset_mode [*8])
    else $error("recovery wait cut short");
  a_wait_answer: assert property (
    (avs_read || avs_write) && avs_waitrequest
      |-> ##[1:2] !avs_waitrequest)
    else $error("bus access not answered in two cycles");
  a_wait_pulse: assert property (
    !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_wait_cause: assert property (
    $fell(avs_waitrequest) |-> $past(avs_read) || $past(avs_write))
    else $error("waitrequest dropped with no request");
  a_unmapped_zero: assert property (
    avs_read && !avs_waitrequest && avs_address[2]
      |-> avs_readdata == 32'h0)
    else $error("unmapped read returned nonzero");
endmodule : sfprs_top_sva

bind sfprs_top sfprs_top_sva i_sfprs_top_sva (
  .ref_clk                (ref_clk),
  .sys_rst                (sys_rst),
  .hw_clear_n             (hw_clear_n),
  .supply_above_threshold (supply_above_threshold),
  .avs_address            (avs_address),
  .avs_read               (avs_read),
  .avs_write              (avs_write),
  .avs_readdata           (avs_readdata),
  .avs_waitrequest        (avs_waitrequest),
  .write_in_progress      (write_in_progress),
  .reset_mode             (reset_mode)
);
`default_nettype wire

// [testbench/sfprs_host_model.sv]
`timescale 1ns/100ps
`default_nettype none
module sfprs_host_model (
  output logic link_sclk,
  output logic device_select_n,
  output logic serial_data_in,
  output logic hw_clear_n
);
  // serial clock idles low and runs only inside frames
  initial
  begin
    link_sclk = 1'b0;
    device_select_n = 1'b1;
    serial_data_in = 1'b1;
    hw_clear_n = 1'b1;
  end

  task automatic clear_pulse();
    hw_clear_n = 1'b0;
    #50;
    hw_clear_n = 1'b1;
    #((sfprs_pkg::RECOVER_CYCLES + 10) * 5);
  endtask : clear_pulse

  task automatic hold_clear(input logic level);
    hw_clear_n = level;
  endtask : hold_clear

  task automatic send_frame(input logic [7:0] op, input int nbits,
                            input logic clr);
    device_select_n = 1'b0;
    #7;
    for (int i = 0; i < nbits; i++)
    begin
      serial_data_in = op[7-i];
      #3 link_sclk = 1'b1;
      #3 link_sclk = 1'b0;
    end
    if (clr)
      hw_clear_n = 1'b0;
    #20;
    device_select_n = 1'b1;
    // released data line must not look held
    serial_data_in = ~serial_data_in;
    #30;
    if (clr)
      clear_pulse();
  endtask : send_frame
endmodule : sfprs_host_model
`default_nettype wire

// [testbench/sfprs_top_test.sv]
`timescale 1ns/100ps
`default_nettype none
module sfprs_top_test;
  localparam int SEL = 20;
  localparam logic [7:0] M_WIP  = 8'h01 << sfprs_pkg::ST_WIP;
  localparam logic [7:0] M_WEL  = 8'h01 << sfprs_pkg::ST_WEL;
  localparam logic [7:0] M_DEEP = 8'h01 << sfprs_pkg::ST_DEEP;
  localparam logic [7:0] M_SEL  = 8'h01 << sfprs_pkg::ST_SEL_OK;
  localparam logic [7:0] M_WOK  = 8'h01 << sfprs_pkg::ST_WRITE_OK;
  logic        ref_clk;
  logic        sys_rst;
  logic        supply_ok;
  logic        supply_min;
  logic [2:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        write_in_progress;
  logic        reset_mode;
  logic        link_sclk;
  logic        device_select_n;
  logic        serial_data_in;
  logic        hw_clear_n;
  logic [31:0] q;
  logic [31:0] lk;
  logic [3:0]  be;
  logic [7:0]  ops [5];
  int          miscompares;
  int          num_checks;
  int          cycles;

  sfprs_top #(.SELECT_CYCLES(SEL), .INHIBIT_CYCLES(400)) i_sfprs_top (
    .ref_clk                (ref_clk),
    .sys_rst                (sys_rst),
    .link_sclk              (link_sclk),
    .device_select_n        (device_select_n),
    .serial_data_in         (serial_data_in),
    .hw_clear_n             (hw_clear_n),
    .supply_above_threshold (supply_ok),
    .supply_above_min       (supply_min),
    .avs_address            (avs_address),
    .avs_read               (avs_read),
    .avs_write              (avs_write),
    .avs_writedata          (avs_writedata),
    .avs_byteenable         (avs_byteenable),
    .avs_readdata           (avs_readdata),
    .avs_waitrequest        (avs_waitrequest),
    .write_in_progress      (write_in_progress),
    .reset_mode             (reset_mode)
  );
  sfprs_host_model i_sfprs_host_model (
    .link_sclk       (link_sclk),
    .device_select_n (device_select_n),
    .serial_data_in  (serial_data_in),
    .hw_clear_n      (hw_clear_n)
  );

  always #2.5 ref_clk = ~ref_clk;

  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      report_and_stop();
    end
  end
//////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  function automatic logic [31:0] lanes(input logic [31:0] d,
                                        input logic [3:0]  b);
    lanes = 32'h0;
    for (int i = 0; i < 2; i++)
      if (b[i])
        lanes[8*i +: 8] = d[8*i +: 8];
  endfunction : lanes

  // holds the request until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [2:0] a,
                     input logic [31:0] d, input logic [3:0] b);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= b;
    avs_write <= wr;
    avs_read <= !wr;
    do
      @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge ref_clk);
  endtask : bus

  task automatic rd(input logic [2:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, 4'h0);
    chk(q, exp);
  endtask : rd

  task automatic st(input logic [7:0] m, input logic [7:0] v);
    bus(1'b0, sfprs_pkg::REG_STATUS, 32'h0, 4'h0);
    chk(q & {24'h0, m}, {24'h0, v});
  endtask : st

  task automatic frame(input logic [7:0] op);
    i_sfprs_host_model.send_frame(op, 8, 1'b0);
    @(posedge ref_clk);
  endtask : frame

  task automatic power(input logic on);
    supply_ok <= on;
    supply_min <= on;
    repeat (SEL + 10) @(posedge ref_clk);
  endtask : power

  initial
  begin
    ref_clk = 1'b0;
    sys_rst = 1'b1;
    supply_ok = 1'b0;
    supply_min = 1'b0;
    avs_address = 3'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
    miscompares = 0;
    num_checks = 0;
    cycles = 0;
    ops = '{sfprs_pkg::OP_WRITE_ENABLE, sfprs_pkg::OP_PAGE_REWRITE,
            sfprs_pkg::OP_PAGE_PROGRAM, sfprs_pkg::OP_PAGE_ERASE,
            sfprs_pkg::OP_LARGE_CLEAR};
    void'($urandom(82));
    repeat (6) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    st(8'hDF, 8'h00);
    rd(sfprs_pkg::REG_LOCK, 32'h0);
    rd(sfprs_pkg::REG_CYCLE, {8'h0, sfprs_pkg::CYCLE_RESET});
    bus(1'b1, 3'h5, 32'hFFFFFFFF, 4'hF);
    rd(3'h5, 32'h0);
    frame(sfprs_pkg::OP_WRITE_ENABLE);
    st(M_WEL, 8'h00);
    chk({31'h0, reset_mode}, 32'h1);
    power(1'b1);
    st(M_SEL | M_WOK, M_SEL);
    foreach (ops[i])
    begin
      frame(ops[i]);
      st(M_WEL | M_WIP, 8'h00);
    end
    do
      bus(1'b0, sfprs_pkg::REG_STATUS, 32'h0, 4'h0);
    while ((q[7:0] & M_WOK) !== M_WOK);
    lk = $urandom();
    be = 4'($urandom());
    bus(1'b1, sfprs_pkg::REG_CYCLE, $urandom_range(90, 40), 4'hF);
    bus(1'b1, sfprs_pkg::REG_LOCK, lk, be);
    rd(sfprs_pkg::REG_LOCK, lanes(lk, be));
    frame(sfprs_pkg::OP_WRITE_ENABLE);
    st(M_WEL, M_WEL);
    frame(sfprs_pkg::OP_PAGE_PROGRAM);
    st(M_WIP, M_WIP);
    i_sfprs_host_model.clear_pulse();
    @(posedge ref_clk);
    chk({31'h0, write_in_progress}, 32'h0);
    st(M_WIP | M_WEL, 8'h00);
    rd(sfprs_pkg::REG_LOCK, 32'h0);
    bus(1'b1, sfprs_pkg::REG_CYCLE, 32'h000000C8, 4'hF);
    bus(1'b1, sfprs_pkg::REG_LOCK, lk, 4'hF);
    frame(sfprs_pkg::OP_WRITE_ENABLE);
    frame(sfprs_pkg::OP_STATUS_WRITE);
    i_sfprs_host_model.clear_pulse();
    @(posedge ref_clk);
    chk({31'h0, write_in_progress}, 32'h1);
    while (write_in_progress !== 1'b0)
      @(posedge ref_clk);
    repeat (8) @(posedge ref_clk);
    chk({31'h0, reset_mode}, 32'h1);
    while (reset_mode !== 1'b0)
      @(posedge ref_clk);
    rd(sfprs_pkg::REG_LOCK, 32'h0);
    bus(1'b1, sfprs_pkg::REG_LOCK, lk, 4'hF);
    i_sfprs_host_model.send_frame(sfprs_pkg::OP_WRITE_ENABLE, 8, 1'b1);
    @(posedge ref_clk);
    st(M_WEL, 8'h00);
    rd(sfprs_pkg::REG_LOCK, 32'h0);
    frame(sfprs_pkg::OP_WRITE_ENABLE);
    st(M_WEL, M_WEL);
    frame(sfprs_pkg::OP_WRITE_DISABLE);
    st(M_WEL, 8'h00);
    frame(sfprs_pkg::OP_WRITE_ENABLE);
    st(M_WEL, M_WEL);
    bus(1'b1, sfprs_pkg::REG_LOCK, lk, 4'hF);
    i_sfprs_host_model.clear_pulse();
    @(posedge ref_clk);
    st(M_WEL, 8'h00);
    rd(sfprs_pkg::REG_LOCK, 32'h0);
    frame(sfprs_pkg::OP_WRITE_ENABLE);
    frame(sfprs_pkg::OP_WHOLE_CLEAR);
    st(M_WIP, M_WIP);
    power(1'b0);
    chk({31'h0, write_in_progress}, 32'h0);
    power(1'b1);
    frame(sfprs_pkg::OP_DEEP_DOWN);
    st(M_DEEP, M_DEEP);
    frame(sfprs_pkg::OP_WRITE_ENABLE);
    st(M_DEEP | M_WEL, M_DEEP);
    rd(sfprs_pkg::REG_LASTOP, {24'h0, sfprs_pkg::OP_WRITE_ENABLE});
    frame(sfprs_pkg::OP_DEEP_RELEASE);
    st(M_DEEP, 8'h00);
    frame(sfprs_pkg::OP_DEEP_DOWN);
    st(M_DEEP, M_DEEP);
    bus(1'b1, sfprs_pkg::REG_LOCK, lk, 4'hF);
    i_sfprs_host_model.hold_clear(1'b0);
    power(1'b0);
    power(1'b1);
    chk({31'h0, reset_mode}, 32'h1);
    i_sfprs_host_model.hold_clear(1'b1);
    st(M_DEEP | M_WEL | M_WIP, 8'h00);
    rd(sfprs_pkg::REG_LOCK, 32'h0);
    report_and_stop();
  end
endmodule : sfprs_top_test
`default_nettype wire
